// file: pmi_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - Write-enable bit 0 writable by fieldbus only; reads 1 under host ownership.
// - Write enable clears at next frame start or end of host access.
// - Status bit 1 tells whether the host may take the interface.
// - Status bit 2 reads 1 when management link detection is active.
// - Bits 7:3 show a configured PHY address of port 0 or selected port.
// - Select bit 7 low shows base address; high shows port from bits 4:0, or the base address if bits 4:0 exceed 3.
// - Command 00 idle and clear errors, 01 read, 10 write, others invalid.
// - Writing the command launches it; reads show the running command.
// - Command field clears when the command finishes and busy drops.
// - Writing idle code clears both error flags.
// - Read error sets on absent PHY; any control write clears it.
// - Command error on invalid code or unenabled write; valid code clears.
// - Busy bit 15 is high while a command executes.
// - Control, PHY select and register select writes ignored while busy.
// - Data register neither read nor written while busy.
// - Only the side owning the interface may write its registers.
// - Register select bits 4:0 pick the PHY register accessed.
// - Ownership bit: 0 gives fieldbus access, 1 gives host access.
module pmi_ctrl #(
  parameter logic [4:0] PHY_BASE_ADDR = 5'h00,
  parameter logic HOST_CTRL_POSSIBLE = 1'h1,
  parameter logic LINK_DETECT = 1'h0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_host,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic frame_start,
  input wire logic host_access_end,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic mdc
);

  logic wr_en_reg;
  pmi_pkg::pmi_cmd_t cmd_reg;
  logic rd_err_reg;
  logic cmd_err_reg;
  logic busy_reg;
  logic start_reg;
  logic [7:0] phy_sel_reg;
  logic [7:0] reg_sel_reg;
  logic [15:0] data_reg;
  logic fb_own_reg;
  logic host_own_reg;
  logic mdio_meta_reg;
  logic mdio_sync_reg;
  logic [4:0] port_addr [pmi_pkg::PMI_PORTS];
  logic [4:0] shown_addr;
  logic [15:0] csr_word;
  logic [7:0] rd_mux;
  logic wr;
  logic grant;
  logic wr_csr_lo;
  logic wr_csr_hi;
  logic wren_eff;
  logic launch_read;
  logic launch_write;
  logic cmd_bad;
  logic [1:0] code;
  logic eng_done;
  pmi_pkg::pmi_req_t eng_req;
  pmi_pkg::pmi_rsp_t eng_rsp;

  // Per-port configured addresses follow the base address in order
  for (genvar i = 0; i < pmi_pkg::PMI_PORTS; i++) begin : g_port
    assign port_addr[i] = PHY_BASE_ADDR + 5'(i);
  end

  always_comb begin
    shown_addr = PHY_BASE_ADDR;
    if (phy_sel_reg[pmi_pkg::PMI_PSEL_SHOW_BIT] &&
        phy_sel_reg[4:0] < 5'(pmi_pkg::PMI_PORTS)) begin
      shown_addr = port_addr[phy_sel_reg[1:0]];
    end
  end

  assign wren_eff = wr_en_reg || host_own_reg;
  assign csr_word = {busy_reg, cmd_err_reg, rd_err_reg, 3'h0, cmd_reg,
    shown_addr, LINK_DETECT, HOST_CTRL_POSSIBLE, wren_eff};

  // Access decode: writes only from the owning side and only when idle
  assign wr = acc_valid && acc_write;
  assign grant = wr && (acc_host == host_own_reg) && !busy_reg;
  assign wr_csr_lo = grant && acc_addr == pmi_pkg::PMI_ADDR_CSR_LO;
  assign wr_csr_hi = grant && acc_addr == pmi_pkg::PMI_ADDR_CSR_HI;
  assign code = acc_wdata[1:0];
  assign launch_read = wr_csr_hi &&
    code == pmi_pkg::PMI_CMD_READ;
  assign launch_write = wr_csr_hi && code == pmi_pkg::PMI_CMD_WRITE &&
    wren_eff;
  assign cmd_bad = wr_csr_hi && (code == pmi_pkg::PMI_CMD_BAD ||
    (code == pmi_pkg::PMI_CMD_WRITE && !wren_eff));

  always_comb begin
    rd_mux = 8'h00;
    case (acc_addr)
      pmi_pkg::PMI_ADDR_CSR_LO: rd_mux = csr_word[7:0];
      pmi_pkg::PMI_ADDR_CSR_HI: rd_mux = csr_word[15:8];
      pmi_pkg::PMI_ADDR_PHY_SEL: rd_mux = phy_sel_reg;
      pmi_pkg::PMI_ADDR_REG_SEL: rd_mux = reg_sel_reg;
      pmi_pkg::PMI_ADDR_DATA_LO: rd_mux = busy_reg ? 8'h00 : data_reg[7:0];
      pmi_pkg::PMI_ADDR_DATA_HI: rd_mux = busy_reg ? 8'h00 : data_reg[15:8];
      pmi_pkg::PMI_ADDR_FB_OWN: rd_mux = {7'h00, fb_own_reg};
      pmi_pkg::PMI_ADDR_HOST_OWN: rd_mux = {7'h00, host_own_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_rdata <= 8'h00;
      acc_rvalid <= 1'h0;
    end else if (ce) begin
      acc_rvalid <= acc_valid && !acc_write;
      if (acc_valid && !acc_write) begin
        acc_rdata <= rd_mux;
      end
    end
  end

  // Only the fieldbus can hold the interface while host owns nothing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_en_reg <= 1'h0;
    end else if (ce) begin
      if (wr_csr_lo && !acc_host) begin
        wr_en_reg <= acc_wdata[pmi_pkg::PMI_CSR_WREN_BIT];
      end else if (frame_start || host_access_end) begin
        wr_en_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fb_own_reg <= 1'h0;
      host_own_reg <= 1'h0;
    end else if (ce) begin
      if (wr && !acc_host && acc_addr == pmi_pkg::PMI_ADDR_FB_OWN &&
          !host_own_reg) begin
        fb_own_reg <= acc_wdata[0];
      end
      if (wr && !acc_host && acc_addr == pmi_pkg::PMI_ADDR_HOST_OWN &&
          acc_wdata[pmi_pkg::PMI_HOST_FORCE_BIT]) begin
        host_own_reg <= 1'h0;
      end else if (wr && acc_host && !busy_reg &&
                   acc_addr == pmi_pkg::PMI_ADDR_HOST_OWN &&
                   !fb_own_reg && HOST_CTRL_POSSIBLE) begin
        host_own_reg <= acc_wdata[0];
      end
    end
  end

  // Launch and completion never coincide: launch needs busy low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= pmi_pkg::PMI_CMD_IDLE;
      busy_reg <= 1'h0;
      start_reg <= 1'h0;
    end else if (ce) begin
      start_reg <= launch_read || launch_write;
      if (launch_read || launch_write) begin
        cmd_reg <= pmi_pkg::pmi_cmd_t'(code);
        busy_reg <= 1'h1;
      end else if (eng_done) begin
        cmd_reg <= pmi_pkg::PMI_CMD_IDLE;
        busy_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_err_reg <= 1'h0;
      cmd_err_reg <= 1'h0;
    end else if (ce) begin
      if (eng_done && eng_rsp.err) begin
        rd_err_reg <= 1'h1;
      end else if (wr_csr_lo || wr_csr_hi) begin
        rd_err_reg <= 1'h0;
      end
      if (cmd_bad) begin
        cmd_err_reg <= 1'h1;
      end else if (wr_csr_hi) begin
        cmd_err_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phy_sel_reg <= pmi_pkg::PMI_SEL_RESET;
      reg_sel_reg <= pmi_pkg::PMI_SEL_RESET;
    end else if (ce) begin
      if (grant && acc_addr == pmi_pkg::PMI_ADDR_PHY_SEL) begin
        phy_sel_reg <= {acc_wdata[7], 2'h0, acc_wdata[4:0]};
      end
      if (grant && acc_addr == pmi_pkg::PMI_ADDR_REG_SEL) begin
        reg_sel_reg <= acc_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= pmi_pkg::PMI_DATA_RESET;
    end else if (ce) begin
      if (eng_done && cmd_reg == pmi_pkg::PMI_CMD_READ && !eng_rsp.err) begin
        data_reg <= eng_rsp.rdata;
      end else if (grant && acc_addr == pmi_pkg::PMI_ADDR_DATA_LO) begin
        data_reg[7:0] <= acc_wdata;
      end else if (grant && acc_addr == pmi_pkg::PMI_ADDR_DATA_HI) begin
        data_reg[15:8] <= acc_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mdio_meta_reg <= 1'h1;
      mdio_sync_reg <= 1'h1;
    end else if (ce) begin
      mdio_meta_reg <= mdio_in;
      mdio_sync_reg <= mdio_meta_reg;
    end
  end

  // Selects cannot change while busy, so the request is read live
  assign eng_req = '{read: cmd_reg == pmi_pkg::PMI_CMD_READ,
    phy_addr: phy_sel_reg[4:0], reg_addr: reg_sel_reg[4:0],
    wdata: data_reg};

  pmi_mdio_engine u_engine (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .start(start_reg),
    .req(eng_req),
    .mdio_in_sync(mdio_sync_reg),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .done(eng_done),
    .rsp(eng_rsp)
  );

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn || !ce);

  sequence launch_s;
    launch_read || launch_write;
  endsequence

  sequence run_s;
    busy_reg [*8];
  endsequence

  host_wren_a: assert property (host_own_reg && acc_valid &&
    !acc_write && acc_addr == pmi_pkg::PMI_ADDR_CSR_LO |=> acc_rdata[0])
    else $error("write enable not forced under host ownership");
  wren_clear_a: assert property ((frame_start || host_access_end) &&
    !(wr_csr_lo && !acc_host) |=> !wr_en_reg)
    else $error("write enable survived frame start");
  cmd_done_a: assert property (eng_done |=>
    cmd_reg == pmi_pkg::PMI_CMD_IDLE && !busy_reg)
    else $error("command field not cleared at completion");
  idle_clear_a: assert property (wr_csr_hi &&
    code == pmi_pkg::PMI_CMD_IDLE |=> !cmd_err_reg && !rd_err_reg)
    else $error("idle command left an error set");
  bad_cmd_a: assert property (wr_csr_hi &&
    code == pmi_pkg::PMI_CMD_BAD |=> cmd_err_reg && !busy_reg)
    else $error("invalid command not flagged");
  busy_run_a: assert property (launch_s |=> run_s)
    else $error("busy not held after launch");
  sel_hold_a: assert property (busy_reg && wr &&
    acc_addr == pmi_pkg::PMI_ADDR_PHY_SEL |=> $stable(phy_sel_reg))
    else $error("PHY select changed while busy");
  data_block_a: assert property (busy_reg && acc_valid && !acc_write &&
    acc_addr == pmi_pkg::PMI_ADDR_DATA_LO |=> acc_rdata == 8'h00)
    else $error("data readable while busy");
  read_load_a: assert property (eng_done && !eng_rsp.err &&
    cmd_reg == pmi_pkg::PMI_CMD_READ |=> data_reg == $past(eng_rsp.rdata))
    else $error("read data not loaded");
  rderr_set_a: assert property (eng_done && eng_rsp.err |=>
    rd_err_reg)
    else $error("read error not flagged");
  // A refused side must not disturb the register select the owner set up
  wr_block_a: assert property (wr && acc_host != host_own_reg &&
    acc_addr == pmi_pkg::PMI_ADDR_REG_SEL |=> $stable(reg_sel_reg))
    else $error("register select written by non-owner");

endmodule : pmi_ctrl

// file: pmi_mdio_engine.sv
`timescale 1ns/100ps
module pmi_mdio_engine (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input pmi_pkg::pmi_req_t req,
  input wire logic mdio_in_sync,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  output logic done,
  output pmi_pkg::pmi_rsp_t rsp
);

  pmi_pkg::pmi_eng_state_t state_reg;
  logic [5:0] div_reg;
  logic [5:0] bit_reg;
  logic [63:0] tx_reg;
  logic [15:0] rx_reg;
  logic err_reg;
  logic read_reg;
  logic half_end;
  logic [63:0] frame;

  assign half_end = (div_reg == pmi_pkg::PMI_MDC_HALF_CYC - 6'h01);
  assign frame = {pmi_pkg::PMI_FRM_PREAMBLE, pmi_pkg::PMI_FRM_START,
    req.read ? pmi_pkg::PMI_FRM_OP_RD : pmi_pkg::PMI_FRM_OP_WR,
    req.phy_addr, req.reg_addr, pmi_pkg::PMI_FRM_TA_WR, req.wdata};

  // Sequencing, serial clock and drive; data changes on the same clock edge that drops MDC
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= pmi_pkg::PMI_ENG_IDLE;
      div_reg <= 6'h00;
      bit_reg <= 6'h00;
      tx_reg <= 64'h0000_0000_0000_0000;
      read_reg <= 1'h0;
      mdc <= 1'h0;
      mdio_out <= 1'h1;
      mdio_oe <= 1'h0;
    end else if (ce) begin
      case (state_reg)
        pmi_pkg::PMI_ENG_IDLE: begin
          if (start) begin
            tx_reg <= frame;
            mdio_out <= frame[63];
            mdio_oe <= 1'h1;
            read_reg <= req.read;
            bit_reg <= 6'h00;
            div_reg <= 6'h00;
            state_reg <= pmi_pkg::PMI_ENG_LOW;
          end
        end
        pmi_pkg::PMI_ENG_LOW: begin
          if (half_end) begin
            div_reg <= 6'h00;
            mdc <= 1'h1;
            state_reg <= pmi_pkg::PMI_ENG_HIGH;
          end else begin
            div_reg <= div_reg + 6'h01;
          end
        end
        pmi_pkg::PMI_ENG_HIGH: begin
          if (!half_end) begin
            div_reg <= div_reg + 6'h01;
          end else begin
            div_reg <= 6'h00;
            mdc <= 1'h0;
            if (bit_reg == pmi_pkg::PMI_FRM_LAST_BIT) begin
              mdio_oe <= 1'h0;
              mdio_out <= 1'h1;
              state_reg <= pmi_pkg::PMI_ENG_END;
            end else begin
              bit_reg <= bit_reg + 6'h01;
              tx_reg <= {tx_reg[62:0], 1'h0};
              mdio_out <= tx_reg[62];
              // The PHY owns the line from turnaround on during a read
              mdio_oe <= !(read_reg &&
                (bit_reg + 6'h01 >= pmi_pkg::PMI_FRM_TA_FIRST));
              state_reg <= pmi_pkg::PMI_ENG_LOW;
            end
          end
        end
        pmi_pkg::PMI_ENG_END: begin
          state_reg <= pmi_pkg::PMI_ENG_IDLE;
        end
        default: begin
          state_reg <= pmi_pkg::PMI_ENG_IDLE;
        end
      endcase
    end
  end

  // Sampling late in the high phase leaves room for the input synchroniser
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_reg <= 16'h0000;
      err_reg <= 1'h0;
    end else if (ce) begin
      if (state_reg == pmi_pkg::PMI_ENG_IDLE && start) begin
        err_reg <= 1'h0;
      end else if (state_reg == pmi_pkg::PMI_ENG_HIGH && half_end &&
                   read_reg) begin
        // An absent PHY leaves the pulled-up line high in turnaround
        if (bit_reg == pmi_pkg::PMI_FRM_TA_LAST) begin
          err_reg <= mdio_in_sync;
        end
        if (bit_reg > pmi_pkg::PMI_FRM_TA_LAST) begin
          rx_reg <= {rx_reg[14:0], mdio_in_sync};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'h0;
      rsp <= '0;
    end else if (ce) begin
      done <= (state_reg == pmi_pkg::PMI_ENG_END);
      if (state_reg == pmi_pkg::PMI_ENG_END) begin
        rsp.rdata <= rx_reg;
        rsp.err <= read_reg && err_reg;
      end
    end
  end

endmodule : pmi_mdio_engine

// file: pmi_phy_model.sv
`timescale 1ns/100ps
module pmi_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h05
) (
  input wire logic mdc,
  input wire logic mdio,
  input wire logic slow,
  output logic drive_en,
  output logic drive_val
);
  logic [15:0] regs [32];
  logic [63:0] sr;
  logic [15:0] shadow;
  logic [1:0] op;
  logic [4:0] phy;
  logic [4:0] ra;
  logic in_frame;
  logic rd_hit;
  int ones;
  int pos;

  initial begin
    for (int r = 0; r < 32; r++) begin
      regs[r] = 16'hA500 | 16'(r);
    end
    sr = 64'h0000_0000_0000_0000;
    shadow = 16'h0000;
    in_frame = 1'h0;
    rd_hit = 1'h0;
    ones = 0;
    pos = 0;
    drive_en = 1'h0;
    drive_val = 1'h0;
  end

  // Serial bits are taken on the rising clock edge
  always @(posedge mdc) begin
    sr = {sr[62:0], mdio};
    if (!in_frame) begin
      if (mdio === 1'h1) begin
        ones++;
      end else begin
        in_frame = (ones >= 32);
        pos = 32;
        ones = 0;
      end
    end else begin
      pos++;
      if (pos == 45) begin
        op = sr[11:10];
        phy = sr[9:5];
        ra = sr[4:0];
        rd_hit = (op == 2'h2) && (phy == PHY_ADDR);
        shadow = regs[ra];
      end
      if (pos == 63) begin
        if (op == 2'h1 && phy == PHY_ADDR) begin
          regs[ra] = sr[15:0];
        end
        in_frame = 1'h0;
        rd_hit = 1'h0;
      end
    end
  end

  // Absent address never drives, so the pull-up reads back as all ones
  always @(negedge mdc) begin
    #(slow ? 150 : 5);
    drive_en = in_frame && rd_hit && pos >= 46;
    drive_val = (pos >= 47) ? shadow[4'(62 - pos)] : 1'h0;
  end
endmodule : pmi_phy_model

// file: pmi_pkg.sv
package pmi_pkg;

  // Byte addresses of the management register group
  localparam logic [15:0] PMI_ADDR_CSR_LO = 16'h0510;
  localparam logic [15:0] PMI_ADDR_CSR_HI = 16'h0511;
  localparam logic [15:0] PMI_ADDR_PHY_SEL = 16'h0512;
  localparam logic [15:0] PMI_ADDR_REG_SEL = 16'h0513;
  localparam logic [15:0] PMI_ADDR_DATA_LO = 16'h0514;
  localparam logic [15:0] PMI_ADDR_DATA_HI = 16'h0515;
  localparam logic [15:0] PMI_ADDR_FB_OWN = 16'h0516;
  localparam logic [15:0] PMI_ADDR_HOST_OWN = 16'h0517;
  localparam logic [15:0] PMI_ADDR_PORT_FIRST = 16'h0518;
  localparam logic [15:0] PMI_ADDR_PORT_LAST = 16'h051B;

  // Field positions
  localparam int PMI_CSR_WREN_BIT = 0;
  localparam int PMI_CSR_CMD_LSB = 8;
  localparam int PMI_CSR_RDERR_BIT = 13;
  localparam int PMI_CSR_CMDERR_BIT = 14;
  localparam int PMI_CSR_BUSY_BIT = 15;
  localparam int PMI_HI_RDERR_BIT = 5;
  localparam int PMI_PSEL_SHOW_BIT = 7;
  localparam int PMI_HOST_FORCE_BIT = 1;
  localparam int PMI_PORTS = 4;

  // Reset values
  localparam logic [7:0] PMI_SEL_RESET = 8'h00;
  localparam logic [15:0] PMI_DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PMI_CMD_IDLE = 2'h0,
    PMI_CMD_READ = 2'h1,
    PMI_CMD_WRITE = 2'h2,
    PMI_CMD_BAD = 2'h3
  } pmi_cmd_t;

  typedef enum logic [1:0] {
    PMI_ENG_IDLE = 2'h0,
    PMI_ENG_LOW = 2'h1,
    PMI_ENG_HIGH = 2'h3,
    PMI_ENG_END = 2'h2
  } pmi_eng_state_t;

  // Management frame layout, counted from the first preamble bit
  localparam logic [1:0] PMI_FRM_START = 2'h1;
  localparam logic [1:0] PMI_FRM_OP_RD = 2'h2;
  localparam logic [1:0] PMI_FRM_OP_WR = 2'h1;
  localparam logic [1:0] PMI_FRM_TA_WR = 2'h2;
  localparam logic [31:0] PMI_FRM_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [5:0] PMI_FRM_TA_FIRST = 6'h2E;
  localparam logic [5:0] PMI_FRM_TA_LAST = 6'h2F;
  localparam logic [5:0] PMI_FRM_LAST_BIT = 6'h3F;

  // Serial clock timing
  localparam int PMI_CLK_NS = 5;
  localparam int PMI_MDC_HALF_NS = 200;
  localparam logic [5:0] PMI_MDC_HALF_CYC =
    6'((PMI_MDC_HALF_NS + PMI_CLK_NS - 1) / PMI_CLK_NS);

  typedef struct packed {
    logic read;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } pmi_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic err;
  } pmi_rsp_t;

endpackage : pmi_pkg

// file: tb.sv
`timescale 1ns/100ps
module tb;
  localparam logic FB = 1'h0;
  localparam logic HST = 1'h1;
  logic core_clk = 1'h0;
  logic resetn = 1'h0;
  logic acc_valid = 1'h0;
  logic acc_write = 1'h0;
  logic acc_host = 1'h0;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0] acc_wdata = 8'h00;
  logic frame_start = 1'h0;
  logic host_access_end = 1'h0;
  logic slow = 1'h0;
  logic [7:0] acc_rdata;
  logic acc_rvalid;
  logic mdio_out;
  logic mdio_oe;
  logic mdc;
  logic phy_en;
  logic phy_val;
  logic mdio_line;
  int n_errors = 0;
  int n_compared = 0;

  always #2.5 core_clk = ~core_clk;

  // Line has a pull-up when nobody drives it
  assign mdio_line = mdio_oe ? mdio_out : (phy_en ? phy_val : 1'h1);

  pmi_ctrl #(.PHY_BASE_ADDR(5'h04)) pmi_ctrl_i (
    .core_clk(core_clk), .resetn(resetn), .ce(1'h1),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_host(acc_host),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .frame_start(frame_start), .host_access_end(host_access_end),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .mdio_in(mdio_line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc)
  );

  pmi_phy_model #(.PHY_ADDR(5'h05)) pmi_phy_model_i (
    .mdc(mdc), .mdio(mdio_line), .slow(slow),
    .drive_en(phy_en), .drive_val(phy_val)
  );

  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic h, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    acc_valid = 1'h1;
    acc_write = 1'h1;
    acc_host = h;
    acc_addr = a;
    acc_wdata = d;
    @(negedge core_clk);
    acc_valid = 1'h0;
    acc_write = 1'h0;
  endtask : wr

  // Returns the answer valid flag above the read byte
  task automatic rd(input logic h, input logic [15:0] a, output logic [8:0] v);
    @(negedge core_clk);
    acc_valid = 1'h1;
    acc_host = h;
    acc_addr = a;
    @(negedge core_clk);
    acc_valid = 1'h0;
    v = {acc_rvalid, acc_rdata};
  endtask : rd

  task automatic rdc(input logic h, input logic [15:0] a, input logic [7:0] e);
    logic [8:0] v;
    rd(h, a, v);
    check({7'h00, v}, {8'h01, e});
  endtask : rdc

  task automatic wait_idle;
    logic [8:0] v;
    for (int i = 0; i < 4000; i++) begin
      rd(FB, pmi_pkg::PMI_ADDR_CSR_HI, v);
      if (v[7] === 1'h0)
        return;
    end
    n_errors++;
    $display("MISMATCH t=%0t busy stuck got=%h exp=%h", $time, v, 9'h100);
    finish_test();
  endtask : wait_idle

  task automatic pulse(input logic k);
    @(negedge core_clk);
    frame_start = !k;
    host_access_end = k;
    @(negedge core_clk);
    frame_start = 1'h0;
    host_access_end = 1'h0;
  endtask : pulse

  initial begin
    logic [15:0] exp;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'h1;
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h22);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h00);
    rdc(FB, 16'h0520, 8'h00);
    $display("test reset values done");
    wr(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h82);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h32);
    wr(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h85);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h22);
    $display("test address display done");
    wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h03);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h40);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h00);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h00);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h02);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h40);
    $display("test command errors done");
    for (int k = 0; k < 2; k++) begin
      wr(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h01);
      rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h23);
      pulse(k[0]);
      rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h22);
    end
    $display("test write enable done");
    wr(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h05);
    wr(FB, pmi_pkg::PMI_ADDR_REG_SEL, 8'h09);
    wr(FB, pmi_pkg::PMI_ADDR_DATA_LO, 8'h34);
    wr(FB, pmi_pkg::PMI_ADDR_DATA_HI, 8'h12);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h01);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h02);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h82);
    wr(FB, pmi_pkg::PMI_ADDR_REG_SEL, 8'h1F);
    wr(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h87);
    wr(FB, pmi_pkg::PMI_ADDR_DATA_LO, 8'hFF);
    rdc(FB, pmi_pkg::PMI_ADDR_DATA_LO, 8'h00);
    wait_idle();
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h00);
    rdc(FB, pmi_pkg::PMI_ADDR_REG_SEL, 8'h09);
    rdc(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h05);
    rdc(FB, pmi_pkg::PMI_ADDR_DATA_LO, 8'h34);
    check(pmi_phy_model_i.regs[9], 16'h1234);
    $display("test serial write done");
    // Prompt and slow answers from the far side
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      exp = k ? 16'h1234 : 16'hA503;
      wr(FB, pmi_pkg::PMI_ADDR_REG_SEL, k ? 8'h09 : 8'h03);
      wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h01);
      rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h81);
      wait_idle();
      rdc(FB, pmi_pkg::PMI_ADDR_DATA_LO, exp[7:0]);
      rdc(FB, pmi_pkg::PMI_ADDR_DATA_HI, exp[15:8]);
    end
    $display("test serial read done");
    wr(FB, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h07);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h01);
    wait_idle();
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h20);
    rdc(FB, pmi_pkg::PMI_ADDR_DATA_LO, 8'h34);
    wr(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h00);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_HI, 8'h00);
    $display("test read error done");
    wr(HST, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h01);
    rdc(FB, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h01);
    rdc(HST, pmi_pkg::PMI_ADDR_CSR_LO, 8'h23);
    wr(HST, pmi_pkg::PMI_ADDR_REG_SEL, 8'h0A);
    wr(FB, pmi_pkg::PMI_ADDR_REG_SEL, 8'h11);
    rdc(HST, pmi_pkg::PMI_ADDR_REG_SEL, 8'h0A);
    wr(HST, pmi_pkg::PMI_ADDR_PHY_SEL, 8'h05);
    wr(HST, pmi_pkg::PMI_ADDR_CSR_HI, 8'h01);
    wait_idle();
    rdc(HST, pmi_pkg::PMI_ADDR_DATA_LO, 8'h0A);
    rdc(HST, pmi_pkg::PMI_ADDR_DATA_HI, 8'hA5);
    wr(FB, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h02);
    rdc(FB, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h00);
    wr(HST, pmi_pkg::PMI_ADDR_CSR_LO, 8'h01);
    rdc(FB, pmi_pkg::PMI_ADDR_CSR_LO, 8'h22);
    // Fieldbus claim locks the host out of taking the interface
    wr(FB, pmi_pkg::PMI_ADDR_FB_OWN, 8'h01);
    rdc(FB, pmi_pkg::PMI_ADDR_FB_OWN, 8'h01);
    wr(HST, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h01);
    rdc(FB, pmi_pkg::PMI_ADDR_HOST_OWN, 8'h00);
    $display("test ownership done");
    finish_test();
  end
endmodule : tb
